/* design/can_acceptance_filter_match.sv */
/*
  Acceptance filter bank: sixteen filters, three masks, mask selection and
  destination routing, with a word-indexed register port.
  Assumes the protocol engine on the same clock gives one-cycle rx_valid
  pulses with the identifier fields held beside them.
*/
// Added by the designer: the address-and-strobe port and the address map.
// How it works
// - Type compare on, select set: extended only
// - Type compare on, select clear: standard only
// - Type compare off: both types, bits match
// - Top two extended bits compared, bits 1-0
// - Lower sixteen extended bits compared under the mask
// - Standard register bits 4, 2 read zero
// - Filters 12-15 pointers; F FIFO, E buffer 14
// - Pointer 0000 routes to receive buffer zero
// - Mask source 00-10 picks mask, 11 none
`timescale 1ns/1ps
`default_nettype none
module can_acceptance_filter_match (
  input  wire logic        clock,           // 200 MHz system clock
  input  wire logic        reset_n,         // Asynchronous, active low
  input  wire logic [5:0]  reg_addr,        // Register index
  input  wire logic [15:0] reg_wdata,       // Write data
  input  wire logic        reg_wr,          // Write strobe
  input  wire logic        reg_rd,          // Read strobe
  output logic      [15:0] reg_rdata,       // Read data, cycle after reg_rd
  input  wire logic        rx_valid,        // Identifier present, one cycle
  input  wire logic        rx_extended,     // Extended frame
  input  wire logic [10:0] rx_sid,          // Standard identifier
  input  wire logic [17:0] rx_eid,          // Extended identifier bits
  output logic             accept_valid,    // Result pulse, cycle after rx_valid
  output logic             accepted,        // Some enabled filter hit
  output logic      [3:0]  hit_filter,      // Lowest hitting filter
  output logic             dest_known,      // Hit filter has a pointer here
  output logic      [3:0]  hit_destination, // Buffer number
  output logic             to_fifo          // Route to receive FIFO
);
  // ************************************************************
  // Register storage
  // ************************************************************
  localparam int NF = can_filter_pkg::NUM_FILTERS;
  localparam int NM = can_filter_pkg::NUM_MASKS;

  logic [15:0] sid_ff      [NF];  // Standard patterns; reset to zero
  logic [15:0] eid_ff      [NF];  // Extended patterns
  logic [15:0] mask_sid_ff [NM];  // Mask standard parts
  logic [15:0] mask_eid_ff [NM];  // Mask extended parts
  logic [15:0] ptr4_ff;           // Filter 12-15 destinations
  logic [31:0] msksel_ff;         // Two bits per filter
  logic [15:0] enable_ff;         // Filter enables
  logic [15:0] rdata_ff;          // Read data holding
  logic [15:0] nxt_rdata;

  // Pattern writes; reset to zero so a fresh bank is deterministic
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NF; i++) begin
        sid_ff[i] <= can_filter_pkg::REG_RST;
        eid_ff[i] <= can_filter_pkg::REG_RST;
      end
    end else if (reg_wr) begin
      for (int i = 0; i < NF; i++) begin
        // Unimplemented bits never store a one
        if (reg_addr == can_filter_pkg::SID_BASE + 6'(i)) begin
          sid_ff[i] <= reg_wdata & can_filter_pkg::SID_WR_MASK;
        end
        if (reg_addr == can_filter_pkg::EID_BASE + 6'(i)) begin
          eid_ff[i] <= reg_wdata;
        end
      end
    end
  end

  // Mask register writes, same layout as the patterns
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int m = 0; m < NM; m++) begin
        mask_sid_ff[m] <= can_filter_pkg::REG_RST;
        mask_eid_ff[m] <= can_filter_pkg::REG_RST;
      end
    end else if (reg_wr) begin
      for (int m = 0; m < NM; m++) begin
        if (reg_addr == can_filter_pkg::MASK_BASE + 6'(2 * m)) begin
          mask_sid_ff[m] <= reg_wdata & can_filter_pkg::SID_WR_MASK;
        end
        if (reg_addr == can_filter_pkg::MASK_BASE + 6'(2 * m + 1)) begin
          mask_eid_ff[m] <= reg_wdata;
        end
      end
    end
  end

  // Control registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ptr4_ff   <= can_filter_pkg::PTR4_RST;
      msksel_ff <= {can_filter_pkg::REG_RST, can_filter_pkg::REG_RST};
      enable_ff <= can_filter_pkg::REG_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        can_filter_pkg::PTR4_ADDR:      ptr4_ff         <= reg_wdata;
        can_filter_pkg::MSKSEL_LO_ADDR: msksel_ff[15:0] <= reg_wdata;
        can_filter_pkg::MSKSEL_HI_ADDR: msksel_ff[31:16] <= reg_wdata;
        can_filter_pkg::ENABLE_ADDR:    enable_ff       <= reg_wdata;
        default: begin
          // Other indices hold no control state
        end
      endcase
    end
  end

  // ************************************************************
  // Filter bank
  // ************************************************************
  logic [NF-1:0] match;     // Raw hit per filter
  logic [1:0]    sel [NF];  // Mask source per filter
  logic [NF-1:0] no_mask;

  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : gen_filt
      logic [1:0] msel;  // Index into the masks, 0 when none applies
      assign sel[g]     = msksel_ff[2*g +: 2];
      assign no_mask[g] = (sel[g] == can_filter_pkg::MASK_NONE);
      assign msel       = no_mask[g] ? 2'h0 : sel[g];
      filter_compare u_cmp (
        .pat_sid     (sid_ff[g]),
        .pat_eid     (eid_ff[g]),
        .msk_sid     (mask_sid_ff[msel]),
        .msk_eid     (mask_eid_ff[msel]),
        .no_mask     (no_mask[g]),
        .rx_extended (rx_extended),
        .rx_sid      (rx_sid),
        .rx_eid      (rx_eid),
        .match       (match[g])
      );

      ext_only_a: assert property (@(posedge clock) disable iff (!reset_n)
        (no_mask[g] || mask_sid_ff[msel][can_filter_pkg::TYPE_BIT])
        && sid_ff[g][can_filter_pkg::TYPE_BIT] && !rx_extended |-> !match[g])
        else $error("type-select filter hit a standard frame");
      std_only_a: assert property (@(posedge clock) disable iff (!reset_n)
        (no_mask[g] || mask_sid_ff[msel][can_filter_pkg::TYPE_BIT])
        && !sid_ff[g][can_filter_pkg::TYPE_BIT] && rx_extended |-> !match[g])
        else $error("standard-only filter hit an extended frame");
      type_ignored_a: assert property (@(posedge clock) disable iff (!reset_n)
        !no_mask[g] && !mask_sid_ff[msel][can_filter_pkg::TYPE_BIT]
        && rx_sid == sid_ff[g][15:can_filter_pkg::SID_LSB]
        && (!rx_extended || rx_eid == {sid_ff[g][1:0], eid_ff[g]}) |-> match[g])
        else $error("exact identifier missed with type compare off");
      eid_high_a: assert property (@(posedge clock) disable iff (!reset_n)
        no_mask[g] && rx_extended && rx_eid[17:16] != sid_ff[g][1:0] |-> !match[g])
        else $error("upper extended bits mismatch still hit");
      eid_low_a: assert property (@(posedge clock) disable iff (!reset_n)
        no_mask[g] && rx_extended && rx_eid[15:0] != eid_ff[g] |-> !match[g])
        else $error("lower extended bits mismatch still hit");
      sid_cmp_a: assert property (@(posedge clock) disable iff (!reset_n)
        no_mask[g] && rx_sid != sid_ff[g][15:can_filter_pkg::SID_LSB] |-> !match[g])
        else $error("standard bits mismatch still hit");
      open_mask_a: assert property (@(posedge clock) disable iff (!reset_n)
        !no_mask[g] && mask_sid_ff[msel] == 16'h0000 && mask_eid_ff[msel] == 16'h0000
        |-> match[g])
        else $error("all-open mask did not accept");
    end
  endgenerate

  // ************************************************************
  // Priority and routing
  // ************************************************************
  logic [NF-1:0] hits;         // Enabled hits
  logic          nxt_any;
  logic [3:0]    nxt_filter;
  logic          nxt_known;
  logic [3:0]    nxt_dest;

  // Lowest-numbered hitting filter wins; pointers of 0-11 live elsewhere
  always_comb begin
    hits       = match & enable_ff;
    nxt_any    = |hits;
    nxt_filter = 4'h0;
    for (int i = NF - 1; i >= 0; i--) begin
      if (hits[i]) begin
        nxt_filter = 4'(i);
      end
    end
    nxt_known = nxt_any && (nxt_filter >= 4'(can_filter_pkg::FIRST_PTR_FILT));
    nxt_dest  = can_filter_pkg::DEST_BUF0;
    if (nxt_known) begin
      // Code is the buffer number; 0000 is buffer zero
      nxt_dest = ptr4_ff[4*(nxt_filter[1:0]) +: 4];
    end
  end

  logic       acc_valid_ff;
  logic       acc_ff;
  logic [3:0] filt_ff;
  logic       known_ff;
  logic [3:0] dest_ff;
  logic       fifo_ff;

  // Result registers; the pulse follows every identifier
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      acc_valid_ff <= 1'b0;
    end else begin
      acc_valid_ff <= rx_valid;
    end
  end

  // Result fields hold until the next identifier
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      acc_ff   <= 1'b0;
      filt_ff  <= 4'h0;
      known_ff <= 1'b0;
      dest_ff  <= can_filter_pkg::DEST_BUF0;
      fifo_ff  <= 1'b0;
    end else if (rx_valid) begin
      acc_ff   <= nxt_any;
      filt_ff  <= nxt_filter;
      known_ff <= nxt_known;
      dest_ff  <= nxt_dest;
      fifo_ff  <= nxt_known && (nxt_dest == can_filter_pkg::DEST_FIFO);
    end
  end

  assign accept_valid    = acc_valid_ff;
  assign accepted        = acc_ff;
  assign hit_filter      = filt_ff;
  assign dest_known      = known_ff;
  assign hit_destination = dest_ff;
  assign to_fifo         = fifo_ff;

  ptr_route_a: assert property (@(posedge clock) disable iff (!reset_n)
    rx_valid && nxt_any && nxt_filter == 4'hC
    |=> known_ff && dest_ff == $past(ptr4_ff[3:0])
        && fifo_ff == ($past(ptr4_ff[3:0]) == can_filter_pkg::DEST_FIFO))
    else $error("filter 12 routed to wrong destination");
  buf_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
    accept_valid && dest_known && hit_destination == can_filter_pkg::DEST_BUF0
    |-> !to_fifo && accepted)
    else $error("pointer 0000 not routed to buffer zero");

  // ************************************************************
  // Read path
  // ************************************************************
  // Read mux; unmapped indices return zero
  always_comb begin
    nxt_rdata = 16'h0000;
    if (reg_addr[5:4] == 2'h0) begin
      nxt_rdata = sid_ff[reg_addr[3:0]];
    end else if (reg_addr[5:4] == 2'h1) begin
      nxt_rdata = eid_ff[reg_addr[3:0]];
    end else begin
      for (int m = 0; m < NM; m++) begin
        if (reg_addr == can_filter_pkg::MASK_BASE + 6'(2 * m)) begin
          nxt_rdata = mask_sid_ff[m];
        end
        if (reg_addr == can_filter_pkg::MASK_BASE + 6'(2 * m + 1)) begin
          nxt_rdata = mask_eid_ff[m];
        end
      end
      case (reg_addr)
        can_filter_pkg::PTR4_ADDR:      nxt_rdata = ptr4_ff;
        can_filter_pkg::MSKSEL_LO_ADDR: nxt_rdata = msksel_ff[15:0];
        can_filter_pkg::MSKSEL_HI_ADDR: nxt_rdata = msksel_ff[31:16];
        can_filter_pkg::ENABLE_ADDR:    nxt_rdata = enable_ff;
        can_filter_pkg::STATUS_ADDR:    nxt_rdata = {acc_ff, known_ff, 6'h00, filt_ff, dest_ff};
        default: begin
          // Mask indices or unmapped: keep what the loop chose
        end
      endcase
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= reg_rd ? nxt_rdata : 16'h0000;
    end
  end

  assign reg_rdata = rdata_ff;

  unimpl_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
    reg_rd && reg_addr[5:4] == 2'h0 |=> reg_rdata[4] == 1'b0 && reg_rdata[2] == 1'b0)
    else $error("unimplemented standard register bits read as one");
endmodule : can_acceptance_filter_match
`default_nettype wire

/* design/can_filter_pkg.sv */
/*
  Shared constants for the acceptance filter block: register indices, field
  positions, reset values and destination codes.
  Assumes a word-indexed register port with a 6-bit address.
*/
package can_filter_pkg;
  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int          NUM_FILTERS     = 16;    // Filters in the bank
  localparam int          NUM_MASKS       = 3;     // Acceptance masks
  localparam int          FIRST_PTR_FILT  = 12;    // First filter with a pointer here
  // ************************************************************
  // Register indices
  // ************************************************************
  localparam logic [5:0]  SID_BASE        = 6'h00; // Standard pattern, filter n at +n
  localparam logic [5:0]  EID_BASE        = 6'h10; // Extended pattern, filter n at +n
  localparam logic [5:0]  PTR4_ADDR       = 6'h20; // Filter 12-15 destination pointer
  localparam logic [5:0]  MSKSEL_LO_ADDR  = 6'h21; // Mask source, filters 0-7
  localparam logic [5:0]  MSKSEL_HI_ADDR  = 6'h22; // Mask source, filters 8-15
  localparam logic [5:0]  MASK_BASE       = 6'h24; // Mask m standard at +2m, extended +2m+1
  localparam logic [5:0]  ENABLE_ADDR     = 6'h2A; // Filter enable bits
  localparam logic [5:0]  STATUS_ADDR     = 6'h2B; // Last match result
  // ************************************************************
  // Fields
  // ************************************************************
  localparam int          SID_LSB         = 5;     // Pattern bits 15-5
  localparam int          TYPE_BIT        = 3;     // Type select / type compare enable
  localparam logic [15:0] SID_WR_MASK     = 16'hFFEB; // Bits 4 and 2 unimplemented
  localparam int          STAT_ACC_BIT    = 15;    // Status: last frame accepted
  localparam int          STAT_KNOWN_BIT  = 14;    // Status: destination known
  // ************************************************************
  // Codes and reset values
  // ************************************************************
  localparam logic [3:0]  DEST_FIFO       = 4'hF;  // Receive FIFO
  localparam logic [3:0]  DEST_BUF14      = 4'hE;  // Receive buffer 14
  localparam logic [3:0]  DEST_BUF0       = 4'h0;  // Receive buffer 0
  localparam logic [1:0]  MASK_NONE       = 2'h3;  // No mask applied
  localparam logic [15:0] PTR4_RST        = 16'h0000;
  localparam logic [15:0] REG_RST         = 16'h0000;
endpackage : can_filter_pkg

/* design/filter_compare.sv */
/*
  One filter's identifier comparison, purely combinational.
  Assumes the caller has already picked the applied mask for this filter.
*/
`timescale 1ns/1ps
`default_nettype none
module filter_compare (
  input  wire logic [15:0] pat_sid,     // Standard pattern register
  input  wire logic [15:0] pat_eid,     // Extended pattern register
  input  wire logic [15:0] msk_sid,     // Applied mask, standard part
  input  wire logic [15:0] msk_eid,     // Applied mask, extended part
  input  wire logic        no_mask,     // Mask source code 11
  input  wire logic        rx_extended, // Frame carries extended identifier
  input  wire logic [10:0] rx_sid,      // Received standard identifier
  input  wire logic [17:0] rx_eid,      // Received extended bits
  output logic             match        // Filter hit
);
  // ************************************************************
  // Compare
  // ************************************************************
  logic [10:0] sid_care;  // Bits that must equal the pattern
  logic [17:0] eid_care;
  logic        type_cmp;  // Type comparison enabled
  logic        sid_ok;
  logic        eid_ok;
  logic        type_ok;

  // No mask means every bit, and the type, is compared
  always_comb begin
    sid_care = no_mask ? 11'h7FF : msk_sid[15:can_filter_pkg::SID_LSB];
    eid_care = no_mask ? 18'h3FFFF : {msk_sid[1:0], msk_eid};
    type_cmp = no_mask | msk_sid[can_filter_pkg::TYPE_BIT];
    sid_ok   = ((rx_sid ^ pat_sid[15:can_filter_pkg::SID_LSB]) & sid_care) == 11'h000;
    // Standard frames carry no extended bits to compare
    eid_ok   = !rx_extended
             || (((rx_eid ^ {pat_sid[1:0], pat_eid}) & eid_care) == 18'h00000);
    // Type select ignored when the mask leaves type compare off
    type_ok  = !type_cmp || (rx_extended == pat_sid[can_filter_pkg::TYPE_BIT]);
    match    = sid_ok & eid_ok & type_ok;
  end
endmodule : filter_compare
`default_nettype wire

/* sim/can_acceptance_filter_match_tb_top.sv */
/*
  Self-checking testbench for the acceptance filter bank.
  Assumes the register index map and mask layout of the filter package and
  a protocol engine model driving the identifier inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module can_acceptance_filter_match_tb_top;
  // ************************************************************
  // Signals
  // ************************************************************
  logic        clock = 1'b0;      // 200 MHz clock
  logic        reset_n = 1'b0;    // Active-low reset
  logic [5:0]  reg_addr = 6'h00;  // Register index
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        rx_valid, rx_extended, accept_valid, accepted, dest_known, to_fifo;
  logic [10:0] rx_sid;
  logic [17:0] rx_eid;
  logic [3:0]  hit_filter, hit_destination;
  int          n_fail = 0;        // Mismatches
  int          n_compared = 0;    // Comparisons
  int          cycles = 0;        // Timeout counter
  localparam logic [10:0] S = 11'h5A3;   // Stored standard pattern
  localparam logic [17:0] E = 18'h2B7C4; // Stored extended pattern

  always #2.5 clock = ~clock;

  can_acceptance_filter_match dut_u (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_valid(rx_valid), .rx_extended(rx_extended), .rx_sid(rx_sid), .rx_eid(rx_eid),
    .accept_valid(accept_valid), .accepted(accepted), .hit_filter(hit_filter),
    .dest_known(dest_known), .hit_destination(hit_destination), .to_fifo(to_fifo));

  rx_engine_model eng_u (.clock(clock), .rx_valid(rx_valid), .rx_extended(rx_extended),
    .rx_sid(rx_sid), .rx_eid(rx_eid));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data is looked at in the one cycle after the strobe
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
    // Read data stands one cycle only, then the port shows zero
    @(posedge clock);
    #1;
    chk(reg_rdata, 16'h0000);
  endtask : rd

  // Sends a frame and checks the result pulse and the routing fields
  task automatic fr(input logic ext, input logic [10:0] standard_identifier_pattern, input logic [17:0] extended_identifier_pattern,
                    input logic acc, input logic [3:0] filt, input logic [3:0] dest);
    logic known;
    known = acc && (filt >= 4'hC);
    eng_u.send(ext, standard_identifier_pattern, extended_identifier_pattern);
    #1;
    chk({4'h0, accept_valid, accepted, dest_known, 1'b0, hit_filter, hit_destination},
        {4'h0, 1'b1, acc, known, 1'b0, acc ? filt : 4'h0, known ? dest : 4'h0});
    chk({15'h0000, to_fifo}, {15'h0000, known && dest == 4'hF});
    // The result pulse stands one cycle; the fields hold
    @(posedge clock);
    #1;
    chk({15'h0000, accept_valid}, 16'h0000);
  endtask : fr

  // Standard register image: pattern, type select, top extended bits
  function automatic logic [15:0] sidreg(input logic [10:0] s, input logic t, input logic [1:0] h);
    return {s, 1'b0, t, 1'b0, h};
  endfunction : sidreg

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic reset_values();
    rd(can_filter_pkg::PTR4_ADDR, 16'h0000);
    rd(6'h3F, 16'h0000);
    wr(can_filter_pkg::SID_BASE, 16'hFFFF);
    rd(can_filter_pkg::SID_BASE, 16'hFFEB);
  endtask : reset_values

  // Filter 12 alone, no mask: every stored bit and the type must agree
  task automatic exact_match();
    wr(can_filter_pkg::MSKSEL_HI_ADDR, 16'h0300);
    wr(can_filter_pkg::ENABLE_ADDR, 16'h1000);
    wr(can_filter_pkg::SID_BASE + 6'h0C, sidreg(S, 1'b1, E[17:16]));
    wr(can_filter_pkg::EID_BASE + 6'h0C, E[15:0]);
    fr(1'b1, S, E, 1'b1, 4'hC, 4'h0);
    fr(1'b1, S ^ 11'h001, E, 1'b0, 4'h0, 4'h0);
    fr(1'b1, S ^ 11'h400, E, 1'b0, 4'h0, 4'h0);
    fr(1'b1, S, E ^ 18'h10000, 1'b0, 4'h0, 4'h0);
    fr(1'b1, S, E ^ 18'h20000, 1'b0, 4'h0, 4'h0);
    fr(1'b1, S, E ^ 18'h00001, 1'b0, 4'h0, 4'h0);
    fr(1'b1, S, E ^ 18'h08000, 1'b0, 4'h0, 4'h0);
  endtask : exact_match

  // Mask 0 cares for the standard bits only; type compare toggled
  task automatic type_select();
    wr(can_filter_pkg::MASK_BASE, 16'hFFE0);
    wr(can_filter_pkg::MSKSEL_HI_ADDR, 16'h0000);
    fr(1'b0, S, E, 1'b1, 4'hC, 4'h0);
    fr(1'b1, S, 18'h00000, 1'b1, 4'hC, 4'h0);
    fr(1'b0, S ^ 11'h020, E, 1'b0, 4'h0, 4'h0);
    wr(can_filter_pkg::MASK_BASE, 16'hFFE8);
    fr(1'b0, S, E, 1'b0, 4'h0, 4'h0);
    fr(1'b1, S, 18'h00000, 1'b1, 4'hC, 4'h0);
    wr(can_filter_pkg::SID_BASE + 6'h0C, sidreg(S, 1'b0, 2'h0));
    fr(1'b0, S, E, 1'b1, 4'hC, 4'h0);
    fr(1'b1, S, 18'h00000, 1'b0, 4'h0, 4'h0);
    // Masks 1 and 2 still all don't care, so a wrong identifier passes
    wr(can_filter_pkg::MSKSEL_HI_ADDR, 16'h0100);
    fr(1'b1, S ^ 11'h001, E, 1'b1, 4'hC, 4'h0);
    wr(can_filter_pkg::MSKSEL_HI_ADDR, 16'h0200);
    fr(1'b0, S ^ 11'h001, E, 1'b1, 4'hC, 4'h0);
  endtask : type_select

  // Every pointer field with the FIFO, buffer 14, buffer 0 and a middle code
  task automatic routing();
    logic [3:0] codes [4];
    logic [15:0] ptr;
    codes = '{4'hF, 4'hE, 4'h0, 4'h7};
    wr(can_filter_pkg::MASK_BASE, 16'h0000);
    wr(can_filter_pkg::MSKSEL_HI_ADDR, 16'h0000);
    for (int f = 12; f < 16; f++) begin
      for (int c = 0; c < 4; c++) begin
        // Field under test carries the code exactly, the others 0001
        ptr = (16'h1111 & ~(16'h000F << (4 * (f - 12))))
            | ({12'h000, codes[c]} << (4 * (f - 12)));
        wr(can_filter_pkg::PTR4_ADDR, ptr);
        rd(can_filter_pkg::PTR4_ADDR, ptr);
        wr(can_filter_pkg::ENABLE_ADDR, 16'h0001 << f);
        fr(1'b0, S, E, 1'b1, f[3:0], ptr[4 * (f - 12) +: 4]);
      end
    end
    wr(can_filter_pkg::ENABLE_ADDR, 16'h0008);
    fr(1'b1, S, E, 1'b1, 4'h3, 4'h0);
  endtask : routing

  // Mask extended bits, low mask source, priority, status and a mid-run reset
  task automatic status_masks();
    wr(can_filter_pkg::MASK_BASE, 16'hFFFF);
    rd(can_filter_pkg::MASK_BASE, 16'hFFEB);
    wr(can_filter_pkg::MSKSEL_LO_ADDR, 16'h00C0);
    rd(can_filter_pkg::MSKSEL_LO_ADDR, 16'h00C0);
    fr(1'b1, S, E, 1'b0, 4'h0, 4'h0);
    // Mask 0 now cares for extended bits 16 and 0 only
    wr(can_filter_pkg::MASK_BASE, 16'h0001);
    wr(can_filter_pkg::MASK_BASE + 6'h01, 16'h0001);
    rd(can_filter_pkg::MASK_BASE + 6'h01, 16'h0001);
    wr(can_filter_pkg::ENABLE_ADDR, 16'hF000);
    fr(1'b1, S, 18'h00001, 1'b0, 4'h0, 4'h0);
    fr(1'b1, S, 18'h10000, 1'b0, 4'h0, 4'h0);
    // All four enabled filters hit; the lowest one wins
    fr(1'b1, S, 18'h2FFFE, 1'b1, 4'hC, 4'h1);
    wr(can_filter_pkg::STATUS_ADDR, 16'hFFFF);
    rd(can_filter_pkg::STATUS_ADDR, 16'hC0C1);
    // Reset in mid-run clears every register again
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rd(can_filter_pkg::PTR4_ADDR, 16'h0000);
    rd(can_filter_pkg::STATUS_ADDR, 16'h0000);
  endtask : status_masks

  // ************************************************************
  // Main sequence and timeout
  // ************************************************************
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    reset_values();
    exact_match();
    type_select();
    routing();
    status_masks();
    stop_test();
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_fail++;
      stop_test();
    end
  end
endmodule : can_acceptance_filter_match_tb_top
`default_nettype wire

/* sim/rx_engine_model.sv */
/*
  Behavioural model of the protocol engine that hands received identifiers
  to the acceptance filter bank.
  Assumes one clock shared with the filter bank; frames are sent on request
  of the testbench through the send task.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_engine_model (
  input  wire logic        clock,       // System clock
  output logic             rx_valid,    // One-cycle identifier strobe
  output logic             rx_extended, // Frame type
  output logic      [10:0] rx_sid,      // Standard identifier
  output logic      [17:0] rx_eid       // Extended identifier bits
);
  // ************************************************************
  // Idle state
  // ************************************************************
  // Fields idle at all ones, not zero, so a stale sample cannot pass by luck
  initial begin
    rx_valid    = 1'b0;
    rx_extended = 1'b1;
    rx_sid      = 11'h7FF;
    rx_eid      = 18'h3FFFF;
  end

  // ************************************************************
  // Frame delivery
  // ************************************************************
  // One identifier for one cycle; afterwards the fields show the inverse,
  // because the real engine does not hold them once the strobe is gone
  task automatic send(input logic ext, input logic [10:0] standard_identifier_pattern, input logic [17:0] extended_identifier_pattern);
    @(posedge clock);
    rx_valid    <= 1'b1;
    rx_extended <= ext;
    rx_sid      <= standard_identifier_pattern;
    rx_eid      <= extended_identifier_pattern;
    @(posedge clock);
    rx_valid    <= 1'b0;
    rx_extended <= ~ext;
    rx_sid      <= ~standard_identifier_pattern;
    rx_eid      <= ~extended_identifier_pattern;
  endtask : send
endmodule : rx_engine_model
`default_nettype wire
